// [wdtit_top.sv]
// watchdog and interval timer: counter, control registers, reset and interrupt
// Function
// - 8-bit up-counter wrap FF to 00 sets reset flag, overflow flag, and gives watchdog reset when mode bit is zero
// - counter is zero after reset
// - clock-select upper four bits read as ones, writes ignored
// - select 1xxx picks internal division, 0xxx oscillator; resets to 1111
// - medium-speed modes forbid oscillator source and interval mode
// - mode bit changes only through a two-write sequence
// - run starts when run=1, inhibit=0 written while write-enable already set
// - watchdog overflow gives internal reset lasting 256 oscillator cycles
// - software writes counter; counting continues from written value
// - mode bit one: interval timer, interrupt each overflow, no reset
// - every overflow sets flag; reset or interrupt in the same cycle
// - interrupt request while overflow flag, interrupt enable and mode bit all one
// - module clock stop acts only while the run bit is zero
// - overflow flag clears only on a written zero; one leaves it
// - interrupt enable one permits, zero blocks the overflow interrupt
`timescale 1ns/10ps
`include "wdtit_cfg.svh"
module wdtit_top
(
    input  wire logic       core_clk_in,
    input  wire logic       nrst_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       medium_speed_in,
    output logic [7:0]      rdata_out,
    output logic            int_reset_out,
    output logic            interval_irq_out,
    output logic            standby_out
);
    // ============================================================
    // registers
    wdtit_pkg::wdtit_bus_t   bus;
    wdtit_pkg::wdtit_state_t state_r;
    logic [7:0] cnt_r;
    logic [3:0] clksel_r;
    logic       rst_flag_r;
    logic       we_r;
    logic       run_r;
    logic       oflow_r;
    logic       mode_r;
    logic       mode_armed_r;
    logic       irq_en_r;
    logic       clk_stop_r;
    logic [8:0] rst_cnt_r;
    logic [4:0] wr_hit;
    logic [7:0] rd_ctrl_one;
    logic [7:0] rd_ctrl_two;
    logic       int_tick;
    logic       osc_tick;
    logic [7:0] wd;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign wd  = wdata_in;

    // ============================================================
    // decode
    wire  stopped   = clk_stop_r & ~run_r;
    wire  use_osc   = ~clksel_r[3];
    wire  cnt_tick  = run_r & ~stopped & (use_osc ? osc_tick : int_tick);
    wire  overflow  = cnt_tick && (cnt_r == 8'hFF);
    wire  sel_ok    = wd[3] | ~medium_speed_in;
    wire  run_start = wr_hit[2] & we_r & wd[`WDTIT_B_RUN] & ~wd[`WDTIT_B_RUN_INH];
    wire  run_stop  = wr_hit[2] & we_r & ~wd[`WDTIT_B_RUN] & ~wd[`WDTIT_B_RUN_INH];
    // second write of the pair commits the mode bit; interval refused at medium speed
    wire  mode_wr   = wr_hit[3] & mode_armed_r & ~wd[`WDTIT_B_MODE_INH];
    wire  mode_ok   = ~wd[`WDTIT_B_MODE] | ~medium_speed_in;
    wire  oflow_clr = wr_hit[3] & ~wd[`WDTIT_B_OFLOW];
    wire  rf_clr    = wr_hit[2] & we_r & ~wd[`WDTIT_B_RST_FLAG];
    wire  wd_fire   = overflow & ~mode_r;
    wire  rst_last  = osc_tick & (rst_cnt_r == `WDTIT_RST_OSC_CYCLES - 9'h001);

    assign rd_ctrl_one = {rst_flag_r, 1'b1, we_r, 1'b1, 1'b1, run_r, 2'b11};
    assign rd_ctrl_two = {oflow_r, 1'b1, 1'b1, mode_r, irq_en_r, 3'b111};

    // ============================================================
    // submodules
    wdtit_prescaler u_presc
    (
        .core_clk_in  (core_clk_in),
        .nrst_in      (nrst_in),
        .enable_in    (run_r),
        .tap_sel_in   (clksel_r[2:0]),
        .tick_out     (int_tick),
        .osc_tick_out (osc_tick)
    );

    wdtit_regport u_port
    (
        .core_clk_in    (core_clk_in),
        .nrst_in        (nrst_in),
        .bus_in         (bus),
        .rd_counter_in  (cnt_r),
        .rd_clksel_in   ({`WDTIT_CLKSEL_RSVD, clksel_r}),
        .rd_ctrl_one_in (rd_ctrl_one),
        .rd_ctrl_two_in (rd_ctrl_two),
        .rd_clkstop_in  ({7'h00, clk_stop_r}),
        .wr_hit_out     (wr_hit),
        .rdata_out      (rdata_out)
    );

    // ============================================================
    // counter
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cnt_r <= `WDTIT_RST_COUNTER;
        else if (wr_hit[0])
            cnt_r <= wd;
        else if (cnt_tick)
            cnt_r <= cnt_r + 8'h01;
    end

    // ============================================================
    // control registers
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            clksel_r     <= `WDTIT_RST_CLKSEL;
            we_r         <= 1'b0;
            run_r        <= 1'b0;
            mode_r       <= 1'b0;
            mode_armed_r <= 1'b0;
            irq_en_r     <= 1'b0;
            clk_stop_r   <= 1'b0;
        end
        else
        begin
            if (wr_hit[1] && sel_ok)
                clksel_r <= wd[3:0];
            if (wr_hit[2])
                we_r <= wd[`WDTIT_B_CTRL_WE];
            if (run_start)
                run_r <= 1'b1;
            else if (run_stop)
                run_r <= 1'b0;
            // first write with inhibit clear arms, next one takes the bit
            if (wr_hit[3])
                mode_armed_r <= ~wd[`WDTIT_B_MODE_INH] & ~mode_armed_r;
            if (mode_wr && mode_ok)
                mode_r <= wd[`WDTIT_B_MODE];
            if (wr_hit[3])
                irq_en_r <= wd[`WDTIT_B_IRQ_EN];
            if (wr_hit[4])
                clk_stop_r <= wd[`WDTIT_B_CLK_STOP];
        end
    end

    // ============================================================
    // sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            oflow_r    <= 1'b0;
            rst_flag_r <= 1'b0;
        end
        else
        begin
            if (overflow)
                oflow_r <= 1'b1;
            else if (oflow_clr)
                oflow_r <= 1'b0;
            // the reset flag records every wrap, in either mode
            if (overflow)
                rst_flag_r <= 1'b1;
            else if (rf_clr)
                rst_flag_r <= 1'b0;
        end
    end

    // ============================================================
    // internal reset sequencer, counts oscillator ticks
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r   <= wdtit_pkg::WDTIT_IDLE;
            rst_cnt_r <= 9'h000;
        end
        else
        begin
            unique case (state_r)
                wdtit_pkg::WDTIT_IDLE,
                wdtit_pkg::WDTIT_RUNNING:
                begin
                    state_r <= run_r ? wdtit_pkg::WDTIT_RUNNING : wdtit_pkg::WDTIT_IDLE;
                    if (overflow && !mode_r)
                    begin
                        state_r   <= wdtit_pkg::WDTIT_RESET;
                        rst_cnt_r <= 9'h000;
                    end
                end
                wdtit_pkg::WDTIT_RESET:
                begin
                    // a fresh watchdog wrap restarts the full reset length
                    if (wd_fire)
                        rst_cnt_r <= 9'h000;
                    else if (osc_tick)
                        rst_cnt_r <= rst_cnt_r + 9'h001;
                    if (rst_last && !wd_fire)
                        state_r <= wdtit_pkg::WDTIT_IDLE;
                end
                default:
                    state_r <= wdtit_pkg::WDTIT_IDLE;
            endcase
        end
    end

    // ============================================================
    // outputs, all registered
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            int_reset_out    <= 1'b0;
            interval_irq_out <= 1'b0;
            standby_out      <= 1'b0;
        end
        else
        begin
            int_reset_out    <= (overflow && !mode_r) ||
                                (state_r == wdtit_pkg::WDTIT_RESET &&
                                 !(osc_tick && rst_cnt_r == `WDTIT_RST_OSC_CYCLES - 9'h001));
            // the flag alone holds the request; watchdog mode never asks
            interval_irq_out <= mode_r & irq_en_r & (oflow_r | overflow);
            standby_out      <= stopped;
        end
    end

    // ============================================================
    // assertions
    a_counter_wraps: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        overflow && !wr_hit[0] |=> cnt_r == 8'h00 && oflow_r)
        else $error("counter did not wrap to zero with flag set");

    a_clksel_reset: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> clksel_r == 4'hF)
        else $error("clock select not all ones after reset");

    a_speed_guard: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        medium_speed_in && $stable(medium_speed_in) && !$past(mode_r) |-> !mode_r)
        else $error("interval mode entered at medium speed");

    a_run_needs_we: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(run_r) |-> $past(we_r) && $past(wr_hit[2]))
        else $error("run started without write enable");

    a_wd_reset_fires: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        overflow && !mode_r |=> int_reset_out && state_r == wdtit_pkg::WDTIT_RESET)
        else $error("watchdog overflow gave no reset");

    a_interval_no_rst: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        overflow && mode_r |=> !int_reset_out ##0 (interval_irq_out == $past(irq_en_r)))
        else $error("interval overflow handled wrongly");

    a_flag_one_keeps: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        oflow_r && wr_hit[3] && wd[`WDTIT_B_OFLOW] |=> oflow_r)
        else $error("overflow flag cleared by writing one");

    a_irq_blocked: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !irq_en_r && !$past(irq_en_r) |-> !interval_irq_out)
        else $error("interrupt raised while disabled");

    a_standby_gate: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        run_r |=> !standby_out)
        else $error("standby entered while running");

    a_count_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_hit[0] |=> cnt_r == $past(wd))
        else $error("written counter value not loaded");

    a_rst_flag_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        overflow |=> rst_flag_r)
        else $error("reset flag not set by overflow");

    a_counter_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> cnt_r == `WDTIT_RST_COUNTER)
        else $error("counter not zero after reset");

    a_clksel_rsvd: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        bus.rd && (bus.addr == `WDTIT_OFS_CLKSEL) |=> rdata_out[7:4] == `WDTIT_CLKSEL_RSVD)
        else $error("reserved clock select bits not read as ones");

    a_osc_refused: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_hit[1] && medium_speed_in && !wd[3] |=> clksel_r == $past(clksel_r))
        else $error("oscillator source accepted at medium speed");

    a_mode_pair: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $changed(mode_r) |-> $past(mode_wr))
        else $error("mode bit changed without a write pair");

    a_rst_len_cap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        state_r == wdtit_pkg::WDTIT_RESET |-> rst_cnt_r < `WDTIT_RST_OSC_CYCLES)
        else $error("reset length counter past its end");

    a_irq_follows: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        mode_r && irq_en_r && oflow_r |=> interval_irq_out)
        else $error("interval request missing with flag and enable set");

    a_standby_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_stop_r && !run_r |=> standby_out)
        else $error("standby not entered with clock stop and run clear");

endmodule : wdtit_top

// [wdtit_cfg.svh]
// register map, field positions, reset values and timing counts of the watchdog interval timer
`ifndef WDTIT_CFG_SVH
`define WDTIT_CFG_SVH

// ============================================================
// register offsets (word index on the plain register port)
`define WDTIT_OFS_COUNTER    4'h0
`define WDTIT_OFS_CLKSEL     4'h1
`define WDTIT_OFS_CTRL_ONE   4'h2
`define WDTIT_OFS_CTRL_TWO   4'h3
`define WDTIT_OFS_CLKSTOP    4'h4

// ============================================================
// field positions, control/status one
`define WDTIT_B_RST_FLAG     7
`define WDTIT_B_CTRL_WE      5
`define WDTIT_B_RUN_INH      3
`define WDTIT_B_RUN          2
// field positions, control/status two
`define WDTIT_B_OFLOW        7
`define WDTIT_B_MODE_INH     5
`define WDTIT_B_MODE         4
`define WDTIT_B_IRQ_EN       3
// field position, clock stop register
`define WDTIT_B_CLK_STOP     0

// ============================================================
// reset values
`define WDTIT_RST_COUNTER    8'h00
`define WDTIT_RST_CLKSEL     4'hF
`define WDTIT_CLKSEL_RSVD    4'hF

// ============================================================
// timing: internal reset lasts this many oscillator cycles
`define WDTIT_RST_OSC_CYCLES 9'h100
// oscillator tick: one enable pulse every this many plus one core clocks
`define WDTIT_OSC_DIV        8'h0F

`endif

// [wdtit_pkg.sv]
// types shared by the watchdog interval timer files
package wdtit_pkg;

    typedef enum logic [1:0]
    {
        WDTIT_IDLE    = 2'b00,
        WDTIT_RUNNING = 2'b01,
        WDTIT_RESET   = 2'b10
    } wdtit_state_t;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wdtit_bus_t;

endpackage : wdtit_pkg

// [wdtit_prescaler.sv]
// prescaler, held at zero while not enabled, giving the eight internal tick taps and the free running oscillator tick
`timescale 1ns/10ps
`include "wdtit_cfg.svh"
module wdtit_prescaler
#(
    parameter logic [3:0] TAP0 = 4'h1,
    parameter logic [3:0] TAP1 = 4'h2,
    parameter logic [3:0] TAP2 = 4'h3,
    parameter logic [3:0] TAP3 = 4'h4,
    parameter logic [3:0] TAP4 = 4'h5,
    parameter logic [3:0] TAP5 = 4'h6,
    parameter logic [3:0] TAP6 = 4'h7,
    parameter logic [3:0] TAP7 = 4'h8
)
(
    input  wire logic       core_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       enable_in,
    input  wire logic [2:0] tap_sel_in,
    output logic            tick_out,
    output logic            osc_tick_out
);
    logic [15:0] div_r;
    logic [7:0]  osc_r;
    logic [3:0]  tap;
    wire  [15:0] div_nxt = div_r + 16'h0001;

    // each select code maps to one configurable prescaler tap
    assign tap = (tap_sel_in == 3'h0) ? TAP0 :
                 (tap_sel_in == 3'h1) ? TAP1 :
                 (tap_sel_in == 3'h2) ? TAP2 :
                 (tap_sel_in == 3'h3) ? TAP3 :
                 (tap_sel_in == 3'h4) ? TAP4 :
                 (tap_sel_in == 3'h5) ? TAP5 :
                 (tap_sel_in == 3'h6) ? TAP6 : TAP7;

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            div_r        <= 16'h0000;
            osc_r        <= 8'h00;
            tick_out     <= 1'b0;
            osc_tick_out <= 1'b0;
        end
        else
        begin
            div_r        <= enable_in ? div_nxt : 16'h0000;
            // rising edge of the selected divider bit, one pulse per period
            tick_out     <= enable_in & div_nxt[tap] & ~div_r[tap];
            osc_r        <= (osc_r == `WDTIT_OSC_DIV) ? 8'h00 : osc_r + 8'h01;
            osc_tick_out <= (osc_r == `WDTIT_OSC_DIV);
        end
    end
endmodule : wdtit_prescaler

// [wdtit_regport.sv]
// plain register port: strobe decode and one-cycle-late read data
`timescale 1ns/10ps
`include "wdtit_cfg.svh"
module wdtit_regport
(
    input  wire logic               core_clk_in,
    input  wire logic               nrst_in,
    input  wire wdtit_pkg::wdtit_bus_t bus_in,
    input  wire logic [7:0]         rd_counter_in,
    input  wire logic [7:0]         rd_clksel_in,
    input  wire logic [7:0]         rd_ctrl_one_in,
    input  wire logic [7:0]         rd_ctrl_two_in,
    input  wire logic [7:0]         rd_clkstop_in,
    output logic [4:0]              wr_hit_out,
    output logic [7:0]              rdata_out
);
    logic [7:0] rsel;

    // write strobes per register, same cycle as the bus write
    assign wr_hit_out[0] = bus_in.wr && (bus_in.addr == `WDTIT_OFS_COUNTER);
    assign wr_hit_out[1] = bus_in.wr && (bus_in.addr == `WDTIT_OFS_CLKSEL);
    assign wr_hit_out[2] = bus_in.wr && (bus_in.addr == `WDTIT_OFS_CTRL_ONE);
    assign wr_hit_out[3] = bus_in.wr && (bus_in.addr == `WDTIT_OFS_CTRL_TWO);
    assign wr_hit_out[4] = bus_in.wr && (bus_in.addr == `WDTIT_OFS_CLKSTOP);

    // unmapped addresses read as zero
    assign rsel = (bus_in.addr == `WDTIT_OFS_COUNTER)  ? rd_counter_in  :
                  (bus_in.addr == `WDTIT_OFS_CLKSEL)   ? rd_clksel_in   :
                  (bus_in.addr == `WDTIT_OFS_CTRL_ONE) ? rd_ctrl_one_in :
                  (bus_in.addr == `WDTIT_OFS_CTRL_TWO) ? rd_ctrl_two_in :
                  (bus_in.addr == `WDTIT_OFS_CLKSTOP)  ? rd_clkstop_in  : 8'h00;

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rdata_out <= 8'h00;
        else if (bus_in.rd)
            rdata_out <= rsel;
        else
            rdata_out <= 8'h00;
    end
endmodule : wdtit_regport

// [wdtit_test.sv]
// self-checking bench for the watchdog interval timer, driven over its register port
`timescale 1ns/10ps
module wdtit_test;

    // ============================================================
    // signals
    localparam int LIMIT = 20000;
    logic       clk;
    logic       nrst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       med;
    logic [7:0] rdata;
    logic       int_rst;
    logic       irq;
    logic       stby;
    int         err_total;
    int         tests_run;
    int         cyc = 0;
    int         t0;

    // default taps: slowest internal code is tap 7
    wdtit_top dut
    (
        .core_clk_in      (clk),
        .nrst_in          (nrst),
        .addr_in          (addr),
        .wdata_in         (wdata),
        .wr_in            (wr),
        .rd_in            (rd),
        .medium_speed_in  (med),
        .rdata_out        (rdata),
        .int_reset_out    (int_rst),
        .interval_irq_out (irq),
        .standby_out      (stby)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ============================================================
    // helpers
    task stop_test;
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe edge
    task rd_chk(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(nm, e & m, rdata & m);
    endtask : rd_chk

    function automatic logic pick(input int s);
        case (s)
            0:       pick = int_rst;
            1:       pick = irq;
            default: pick = stby;
        endcase
    endfunction : pick

    task wait_out(input string nm, input int s, input logic lvl, input int lim);
        int n;
        n = 0;
        while (pick(s) !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(nm, {7'h00, lvl}, {7'h00, pick(s)});
    endtask : wait_out

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            stop_test();
        end
    end

    // ============================================================
    // main sequence
    initial
    begin
        nrst      = 1'b0;
        addr      = 4'h0;
        wdata     = 8'h00;
        wr        = 1'b0;
        rd        = 1'b0;
        med       = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // reset values and unmapped index
        rd_chk("counter", 4'h0, 8'hFF, 8'h00);
        rd_chk("clksel", 4'h1, 8'hFF, 8'hFF);
        rd_chk("ctrl_one", 4'h2, 8'hAC, 8'h08);
        rd_chk("ctrl_two", 4'h3, 8'hB8, 8'h20);
        rd_chk("unmapped", 4'h5, 8'hFF, 8'h00);
        chk("outs", 8'h00, {5'h00, int_rst, irq, stby});
        // clock select, reserved nibble and medium-speed refusals
        wr_reg(4'h1, 8'h0A);
        rd_chk("clksel", 4'h1, 8'hFF, 8'hFA);
        @(posedge clk);
        med <= 1'b1;
        wr_reg(4'h1, 8'h03);
        rd_chk("clksel_med", 4'h1, 8'hFF, 8'hFA);
        wr_reg(4'h1, 8'h09);
        rd_chk("clksel_int", 4'h1, 8'hFF, 8'hF9);
        wr_reg(4'h3, 8'h10);
        wr_reg(4'h3, 8'h10);
        rd_chk("mode_med", 4'h3, 8'h10, 8'h00);
        @(posedge clk);
        med <= 1'b0;
        // start gating needs write enable already set and inhibit clear
        wr_reg(4'h0, 8'hFF);
        rd_chk("counter_wr", 4'h0, 8'hFF, 8'hFF);
        wr_reg(4'h2, 8'h04);
        rd_chk("run_no_we", 4'h2, 8'h04, 8'h00);
        wr_reg(4'h2, 8'h20);
        wr_reg(4'h2, 8'h0C);
        rd_chk("run_inh", 4'h2, 8'h04, 8'h00);
        wr_reg(4'h1, 8'h0F);
        wr_reg(4'h2, 8'h20);
        wr_reg(4'h2, 8'h04);
        rd_chk("run_on", 4'h2, 8'h04, 8'h04);
        // watchdog overflow one slow tick after FF
        wait_out("wd_reset", 0, 1'b1, 1200);
        t0 = cyc;
        chk("wd_irq", 8'h00, {7'h00, irq});
        rd_chk("rst_flag", 4'h2, 8'h80, 8'h80);
        rd_chk("oflow_flag", 4'h3, 8'h80, 8'h80);
        rd_chk("wrap", 4'h0, 8'hFF, 8'h00);
        wait_out("wd_reset_end", 0, 1'b0, 4300);
        chk("rst_len", 8'h01, {7'h00, (cyc - t0 >= 4080) && (cyc - t0 <= 4112)});
        // clock stop waits for the run bit to clear
        wr_reg(4'h4, 8'h01);
        repeat (3) @(posedge clk);
        #1;
        chk("stby_run", 8'h00, {7'h00, stby});
        wr_reg(4'h2, 8'h20);
        wr_reg(4'h2, 8'h00);
        wait_out("stby_on", 2, 1'b1, 4);
        wr_reg(4'h4, 8'h00);
        wait_out("stby_off", 2, 1'b0, 4);
        // interval mode by a write pair, flag still set from the overflow
        wr_reg(4'h3, 8'h98);
        wr_reg(4'h3, 8'h98);
        rd_chk("ctrl_two", 4'h3, 8'h98, 8'h98);
        wait_out("irq_on", 1, 1'b1, 3);
        wr_reg(4'h3, 8'h90);
        wait_out("irq_mask", 1, 1'b0, 3);
        wr_reg(4'h3, 8'h98);
        wait_out("irq_keep", 1, 1'b1, 3);
        wr_reg(4'h3, 8'h18);
        wait_out("irq_clr", 1, 1'b0, 3);
        rd_chk("oflow_clr", 4'h3, 8'h80, 8'h00);
        // oscillator source, two ticks from FE
        wr_reg(4'h1, 8'h00);
        wr_reg(4'h0, 8'hFE);
        wr_reg(4'h2, 8'h20);
        wr_reg(4'h2, 8'h04);
        wait_out("it_irq", 1, 1'b1, 48);
        chk("it_no_rst", 8'h00, {7'h00, int_rst});
        rd_chk("rst_flag_it", 4'h2, 8'h80, 8'h80);
        wr_reg(4'h2, 8'h20);
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h3, 8'h18);
        wait_out("it_clr", 1, 1'b0, 3);
        // a lone write after a disarm must not commit the mode
        wr_reg(4'h3, 8'h38);
        wr_reg(4'h3, 8'h08);
        rd_chk("mode_single", 4'h3, 8'h10, 8'h10);
        wr_reg(4'h3, 8'h08);
        rd_chk("mode_pair", 4'h3, 8'h10, 8'h00);
        stop_test();
    end

endmodule : wdtit_test
